// file: src/sac_map.vh
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// ----------------------------------------------------------------
// register map (byte addresses, 32-bit aligned words)
// ----------------------------------------------------------------
`define SAC_ADDR_W 8
`define SAC_OFF_CTRL 8'h00
`define SAC_OFF_STEP_CHANGE 8'h04
`define SAC_OFF_POSITION 8'h08
`define SAC_OFF_PHASE 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SAC_CTRL_RES_LSB 0
`define SAC_CTRL_RES_MSB 2
`define SAC_CTRL_SLEEP_BIT 3
`define SAC_SC_LSB 0
`define SAC_SC_MSB 5
`define SAC_PH_MAG_A_LSB 0
`define SAC_PH_MAG_A_MSB 5
`define SAC_PH_POL_A_BIT 6
`define SAC_PH_MAG_B_LSB 8
`define SAC_PH_MAG_B_MSB 13
`define SAC_PH_POL_B_BIT 14

// ----------------------------------------------------------------
// microstep resolution codes
// ----------------------------------------------------------------
`define SAC_RES_FULL1 3'h0
`define SAC_RES_FULL2 3'h1
`define SAC_RES_HALF_COMP 3'h2
`define SAC_RES_HALF_UNCOMP 3'h3
`define SAC_RES_QUARTER 3'h4
`define SAC_RES_EIGHTH 3'h5
`define SAC_RES_SIXTEENTH 3'h6

// ----------------------------------------------------------------
// step grids, offsets, home, reset values
// ----------------------------------------------------------------
`define SAC_GRID_FULL 6'h10
`define SAC_GRID_HALF 6'h08
`define SAC_GRID_QUARTER 6'h04
`define SAC_GRID_EIGHTH 6'h02
`define SAC_GRID_SIXTEENTH 6'h01
`define SAC_OFFSET_FULL2 6'h08
`define SAC_OFFSET_NONE 6'h00
`define SAC_HOME_DEFAULT 6'h08
`define SAC_HOME_FULL1 6'h00
`define SAC_RES_RESET 3'h6
`define SAC_QUADRANT 6'h10
`define SAC_HALF_CYCLE 6'h20
`define SAC_THREE_QUARTER 6'h30
`define SAC_FULL_SCALE_IDX 5'h0F
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// file: src/sac_phase_lut.v
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.vh"

module sac_phase_lut (
   // position
   input wire [5:0] angle,
   input wire uncomp,
   // phase currents
   output reg [5:0] mag_a,
   output reg [5:0] mag_b,
   output reg pol_a,
   output reg pol_b
);

   // ----------------------------------------------------------------
   // quarter-wave table, index 0..16
   // ----------------------------------------------------------------
   function [5:0] phase_table_entry;
      input [4:0] k;
      begin
         case (k)
            5'h00: phase_table_entry = 6'h00;
            5'h01: phase_table_entry = 6'h05;
            5'h02: phase_table_entry = 6'h0B;
            5'h03: phase_table_entry = 6'h12;
            5'h04: phase_table_entry = 6'h17;
            5'h05: phase_table_entry = 6'h1D;
            5'h06: phase_table_entry = 6'h23;
            5'h07: phase_table_entry = 6'h28;
            5'h08: phase_table_entry = 6'h2C;
            5'h09: phase_table_entry = 6'h30;
            5'h0A: phase_table_entry = 6'h34;
            5'h0B: phase_table_entry = 6'h37;
            5'h0C: phase_table_entry = 6'h3A;
            5'h0D: phase_table_entry = 6'h3C;
            5'h0E: phase_table_entry = 6'h3E;
            default: phase_table_entry = 6'h3F;
         endcase
      end
   endfunction

   // sine magnitude; the table is mirrored about each quadrant peak
   function [5:0] sine_mag;
      input [5:0] a;
      reg [4:0] idx;
      begin
         idx = a[4:0];
         if (idx > 5'h10) begin
            sine_mag = phase_table_entry(5'h00 - idx);
         end else begin
            sine_mag = phase_table_entry(idx);
         end
      end
   endfunction

   reg [5:0] cos_angle;

   always @* begin
      cos_angle = angle + `SAC_QUADRANT;
      pol_a = (angle > `SAC_HALF_CYCLE);
      pol_b = (angle > `SAC_QUADRANT) && (angle < `SAC_THREE_QUARTER);
      // intermediate half steps run both phases at full scale
      if (uncomp && (angle[3:0] != 4'h0)) begin
         mag_a = phase_table_entry(`SAC_FULL_SCALE_IDX);
         mag_b = phase_table_entry(`SAC_FULL_SCALE_IDX);
      end else begin
         mag_a = sine_mag(angle);
         mag_b = sine_mag(cos_angle);
      end
   end

endmodule
`default_nettype wire

// file: src/sac_top.v
// How it works
// - each step rising edge moves the angle by the selected resolution's increment
// - serial step change ignores resolution and direction settings entirely
// - sixteenth step moves the angle by exactly one per edge
// - single-phase full step uses only angles 0, 16, 32, 48
// - two-phase full step uses only angles 8, 24, 40, 56
// - compensated half step uses the eight multiples of 8
// - uncompensated half step drives active phases at full-scale entry fifteen
// - quarter step uses the sixteen multiples of 4
// - eighth step uses the 32 even angles
// - quarter, eighth, sixteenth use compensated table currents
// - resolution may change between edges; next edge goes to nearest allowed angle
// - from 57 forward, quarter gives 60 and half gives 0
// - reset or sleep exit sets home: 8, or 0 in single-phase full step
// - all angle arithmetic is modulo 64
// - outputs a 6-bit magnitude and polarity per phase from the table
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.vh"

module sac_top (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // step and direction pins
   input wire step_in,
   input wire dir_in,
   // axi4-lite write address
   input wire awvalid,
   output reg awready,
   input wire [`SAC_ADDR_W-1:0] awaddr,
   input wire [2:0] awprot,
   // axi4-lite write data
   input wire wvalid,
   output reg wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   // axi4-lite write response
   output reg bvalid,
   input wire bready,
   output reg [1:0] bresp,
   // axi4-lite read address
   input wire arvalid,
   output reg arready,
   input wire [`SAC_ADDR_W-1:0] araddr,
   input wire [2:0] arprot,
   // axi4-lite read data
   output reg rvalid,
   input wire rready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   // position and phase currents
   output reg [5:0] step_angle,
   output reg [5:0] mag_a,
   output reg [5:0] mag_b,
   output reg pol_a,
   output reg pol_b
);

   // ----------------------------------------------------------------
   // resolution helpers
   // ----------------------------------------------------------------
   function [5:0] res_grid;
      input [2:0] res;
      begin
         case (res)
            `SAC_RES_FULL1: res_grid = `SAC_GRID_FULL;
            `SAC_RES_FULL2: res_grid = `SAC_GRID_FULL;
            `SAC_RES_HALF_COMP: res_grid = `SAC_GRID_HALF;
            `SAC_RES_HALF_UNCOMP: res_grid = `SAC_GRID_HALF;
            `SAC_RES_QUARTER: res_grid = `SAC_GRID_QUARTER;
            `SAC_RES_EIGHTH: res_grid = `SAC_GRID_EIGHTH;
            // unused code 7 behaves as sixteenth
            default: res_grid = `SAC_GRID_SIXTEENTH;
         endcase
      end
   endfunction

   function [5:0] res_offset;
      input [2:0] res;
      begin
         if (res == `SAC_RES_FULL2) begin
            res_offset = `SAC_OFFSET_FULL2;
         end else begin
            res_offset = `SAC_OFFSET_NONE;
         end
      end
   endfunction

   function [5:0] home_angle;
      input [2:0] res;
      begin
         if (res == `SAC_RES_FULL1) begin
            home_angle = `SAC_HOME_FULL1;
         end else begin
            home_angle = `SAC_HOME_DEFAULT;
         end
      end
   endfunction

   // nearest grid point strictly beyond the angle in the step direction;
   // 6-bit operands wrap naturally, so no explicit modulo is needed
   function [5:0] next_angle;
      input [5:0] a;
      input [2:0] res;
      input fwd;
      reg [5:0] g;
      reg [5:0] o;
      reg [5:0] rel;
      reg [5:0] mask;
      reg [5:0] base;
      begin
         g = res_grid(res);
         o = res_offset(res);
         rel = a - o;
         mask = ~(g - 6'h01);
         if (fwd) begin
            base = (rel & mask) + g;
         end else begin
            base = ((rel + g - 6'h01) & mask) - g;
         end
         next_angle = base + o;
      end
   endfunction

   function addr_is;
      input [`SAC_ADDR_W-1:0] addr;
      input [`SAC_ADDR_W-1:0] off;
      begin
         addr_is = ({addr[`SAC_ADDR_W-1:2], 2'h0} == off);
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [2:0] res_q;
   reg sleep_q;
   reg sleep_prev_q;
   reg step_prev_q;
   reg [5:0] angle_q;
   reg [5:0] angle_d;
   reg aw_have_q;
   reg w_have_q;
   reg [`SAC_ADDR_W-1:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [31:0] rd_mux;
   reg rd_ok;
   wire do_write;
   wire wr_ctrl;
   wire wr_step_change;
   wire wr_known;
   wire step_rise;
   wire sleep_exit;
   wire [5:0] lut_mag_a;
   wire [5:0] lut_mag_b;
   wire lut_pol_a;
   wire lut_pol_b;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   assign do_write = aw_have_q && w_have_q && !bvalid;
   // byte 0 disabled: answered okay, nothing changes
   assign wr_ctrl = do_write && addr_is(awaddr_q, `SAC_OFF_CTRL) && wstrb_q[0];
   assign wr_step_change = do_write && addr_is(awaddr_q, `SAC_OFF_STEP_CHANGE) && wstrb_q[0];
   assign wr_known = addr_is(awaddr_q, `SAC_OFF_CTRL) || addr_is(awaddr_q, `SAC_OFF_STEP_CHANGE) ||
      addr_is(awaddr_q, `SAC_OFF_POSITION) || addr_is(awaddr_q, `SAC_OFF_PHASE);

   // ----------------------------------------------------------------
   // axi write channels
   // ----------------------------------------------------------------
   // address and data are taken independently, one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= {`SAC_ADDR_W{1'b0}};
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `SAC_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // resolution and sleep land together, so a sleep exit homes on the new resolution
   always @(posedge aclk) begin
      if (!aresetn) begin
         res_q <= `SAC_RES_RESET;
         sleep_q <= 1'b0;
      end else if (wr_ctrl) begin
         res_q <= wdata_q[`SAC_CTRL_RES_MSB:`SAC_CTRL_RES_LSB];
         sleep_q <= wdata_q[`SAC_CTRL_SLEEP_BIT];
      end
   end

   // ----------------------------------------------------------------
   // step angle counter
   // ----------------------------------------------------------------
   // step pin is taken as synchronous; one edge detector register
   assign step_rise = step_in && !step_prev_q;
   assign sleep_exit = sleep_prev_q && !sleep_q;

   always @* begin
      angle_d = angle_q;
      if (sleep_exit) begin
         angle_d = home_angle(res_q);
      end else if (sleep_q) begin
         // asleep: neither pins nor serial writes move the motor
         angle_d = angle_q;
      end else if (wr_step_change) begin
         // serial path adds the two's-complement value, no grid, no direction
         angle_d = angle_q + wdata_q[`SAC_SC_MSB:`SAC_SC_LSB];
      end else if (step_rise) begin
         // a coincident step edge loses to a serial write in the same cycle
         angle_d = next_angle(angle_q, res_q, dir_in);
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         step_prev_q <= 1'b0;
         sleep_prev_q <= 1'b0;
         angle_q <= `SAC_HOME_DEFAULT;
      end else begin
         step_prev_q <= step_in;
         sleep_prev_q <= sleep_q;
         angle_q <= angle_d;
      end
   end

   // ----------------------------------------------------------------
   // phase current lookup
   // ----------------------------------------------------------------
   // uncompensated half step is a table override, not a grid of its own
   sac_phase_lut u_lut (
      .angle(angle_q),
      .uncomp(res_q == `SAC_RES_HALF_UNCOMP),
      .mag_a(lut_mag_a),
      .mag_b(lut_mag_b),
      .pol_a(lut_pol_a),
      .pol_b(lut_pol_b)
   );

   // outputs lag the angle by one cycle; they stay consistent with each other
   always @(posedge aclk) begin
      if (!aresetn) begin
         step_angle <= `SAC_HOME_DEFAULT;
         mag_a <= 6'h00;
         mag_b <= 6'h00;
         pol_a <= 1'b0;
         pol_b <= 1'b0;
      end else begin
         step_angle <= angle_q;
         mag_a <= lut_mag_a;
         mag_b <= lut_mag_b;
         pol_a <= lut_pol_a;
         pol_b <= lut_pol_b;
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always @* begin
      rd_mux = 32'h00000000;
      rd_ok = 1'b1;
      if (addr_is(araddr, `SAC_OFF_CTRL)) begin
         rd_mux[`SAC_CTRL_RES_MSB:`SAC_CTRL_RES_LSB] = res_q;
         rd_mux[`SAC_CTRL_SLEEP_BIT] = sleep_q;
      end else if (addr_is(araddr, `SAC_OFF_STEP_CHANGE)) begin
         // write-only trigger, reads back as zero
         rd_mux = 32'h00000000;
      end else if (addr_is(araddr, `SAC_OFF_POSITION)) begin
         rd_mux[`SAC_SC_MSB:`SAC_SC_LSB] = step_angle;
      end else if (addr_is(araddr, `SAC_OFF_PHASE)) begin
         rd_mux[`SAC_PH_MAG_A_MSB:`SAC_PH_MAG_A_LSB] = mag_a;
         rd_mux[`SAC_PH_POL_A_BIT] = pol_a;
         rd_mux[`SAC_PH_MAG_B_MSB:`SAC_PH_MAG_B_LSB] = mag_b;
         rd_mux[`SAC_PH_POL_B_BIT] = pol_b;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // axi read channels
   // ----------------------------------------------------------------
   // data captured at the address edge, so later moves cannot tear a pending answer
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `SAC_RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// file: dv/sac_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sac_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins
   input wire logic step_in,
   input wire logic dir_in,
   // bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // position and phases
   input wire logic [5:0] step_angle,
   input wire logic [5:0] mag_a,
   input wire logic [5:0] mag_b,
   input wire logic pol_a,
   input wire logic pol_b
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // properties
   // ----
   property p_home; $rose(aresetn) |-> step_angle == 6'h08; endproperty
   a_home: assert property (p_home) else $error("angle not home after reset");
   property p_pol; pol_a == (step_angle > 6'h20) && pol_b == (step_angle > 6'h10 && step_angle < 6'h30); endproperty
   a_pol: assert property (p_pol) else $error("phase polarity wrong");
   property p_axis; step_angle[3:0] == 4'h0 |-> (step_angle[4] ? {mag_a, mag_b} : {mag_b, mag_a}) == 12'hFC0; endproperty
   a_axis: assert property (p_axis) else $error("axis magnitudes wrong");
   // one edge moves at most one full step, in the pin's direction
   // the angle moves on the edge that samples the rise and the output one edge later
   property p_step; $rose(step_in) |=> ##1 6'($past(dir_in, 2) ? step_angle - $past(step_angle) : $past(step_angle) - step_angle) inside {[1:16]}; endproperty
   a_step: assert property (p_step) else $error("step moved wrong way or size");
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_rans; arvalid && arready |=> rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
endmodule
bind sac_top sac_chk u_sac_chk (.aclk, .aresetn, .step_in, .dir_in, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .step_angle, .mag_a, .mag_b,
   .pol_a, .pol_b);
`default_nettype wire

// file: dv/sac_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request from bench
   input wire logic req,
   input wire logic fwd,
   input wire logic [1:0] hold,
   // pins
   output logic step_in,
   output logic dir_in,
   output logic done
);
   logic [1:0] cnt_q;
   logic [1:0] st_q;
   // ----
   // pulse sequencer
   // ----
   always @(posedge aclk) begin
      done <= 1'b0;
      if (!aresetn) begin
         st_q <= 2'h0;
         step_in <= 1'b0;
         dir_in <= 1'b1;
         cnt_q <= 2'h0;
      end else if (st_q == 2'h0) begin
         if (req) begin
            dir_in <= fwd;
            cnt_q <= hold;
            st_q <= 2'h1;
         end
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end else begin
         // dir settles before the rise; high and low last hold+1 cycles each
         step_in <= (st_q == 2'h1);
         done <= (st_q == 2'h3);
         st_q <= st_q + 2'h1;
         cnt_q <= hold;
      end
   end
endmodule
`default_nettype wire

// file: dv/sac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.vh"
module sac_top_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req, fwd, done;
   logic step_in, dir_in, awready, wready, bvalid, arready, rvalid, pol_a, pol_b;
   logic [1:0] hold, bresp, rresp, rsp;
   logic [`SAC_ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_v;
   logic [5:0] step_angle, mag_a, mag_b, ea, sc;
   logic [2:0] cur_res;
   int num_errors, cmp_count;
   logic [5:0] qs [0:16] = '{6'h00, 6'h05, 6'h0B, 6'h12, 6'h17, 6'h1D, 6'h23, 6'h28, 6'h2C,
      6'h30, 6'h34, 6'h37, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F};
   sac_top u_sac_top (.aclk, .aresetn, .step_in, .dir_in, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .step_angle, .mag_a, .mag_b, .pol_a, .pol_b);
   sac_ctrl_model u_sac_ctrl_model (.aclk, .aresetn, .req, .fwd, .hold, .step_in, .dir_in, .done);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ----
   // expectations
   // ----
   function automatic logic [5:0] nxt(input logic [5:0] a, input logic [2:0] r, input logic f);
      logic [5:0] g, o;
      g = (r < 2) ? 6'h10 : (r < 4) ? 6'h08 : (r == 4) ? 6'h04 : (r == 5) ? 6'h02 : 6'h01;
      o = (r == 1) ? 6'h08 : 6'h00;
      nxt = f ? ((a - o) & ~(g - 6'h01)) + g + o : ((a - o + g - 6'h01) & ~(g - 6'h01)) - g + o;
   endfunction
   // uncompensated half step holds full scale between the axes
   function automatic logic [5:0] em(input logic [5:0] a);
      if (cur_res == 3'h3 && a[3:0] != 4'h0) return 6'h3F;
      return (a[4:0] > 5'h10) ? qs[6'h20 - a[4:0]] : qs[a[4:0]];
   endfunction
   // allowed angles per resolution, independent of the stepping arithmetic
   function automatic logic on_grid(input logic [5:0] a, input logic [2:0] r);
      case (r)
         3'h0: return a[3:0] == 4'h0;
         3'h1: return a[3:0] == 4'h8;
         3'h2, 3'h3: return a[2:0] == 3'h0;
         3'h4: return a[1:0] == 2'h0;
         3'h5: return a[0] == 1'b0;
         default: return 1'b1;
      endcase
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task chk_pos();
      chk("step_angle", step_angle, ea);
      chk("mag_a", mag_a, em(ea));
      chk("mag_b", mag_b, em(ea + 6'h10));
      chk("pol_a", pol_a, ea > 6'h20);
      chk("pol_b", pol_b, ea > 6'h10 && ea < 6'h30);
   endtask
   // ----
   // drivers
   // ----
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && awready) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && wready) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      repeat ($urandom % 3) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      repeat ($urandom % 3) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task set_res(input logic [2:0] v);
      wr(`SAC_OFF_CTRL, {29'h0, v}, rsp);
      cur_res = v;
   endtask
   task sc_wr(input logic [5:0] v);
      wr(`SAC_OFF_STEP_CHANGE, {26'h0, v}, rsp);
      repeat (3) @(posedge aclk);
      ea = ea + v;
   endtask
   task step(input logic d);
      @(posedge aclk);
      req <= 1'b1;
      fwd <= d;
      hold <= 2'($urandom % 3);
      @(posedge aclk);
      req <= 1'b0;
      do @(posedge aclk); while (done !== 1'b1);
      @(posedge aclk);
      ea = nxt(ea, cur_res, d);
      chk("on_grid", on_grid(step_angle, cur_res), 1'b1);
   endtask
   task stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      num_errors++;
      $display("unexpected run_end expected done seen hang");
      stop_test();
   end
   // ----
   // tests
   // ----
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, req, hold} = '0;
      {fwd, awaddr, araddr, wdata, num_errors, cmp_count} = '0;
      ea = 6'h08;
      cur_res = `SAC_RES_RESET;
      sc = 6'($urandom(52884));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_pos();
      rd(`SAC_OFF_CTRL, rd_v, rsp);
      chk("ctrl", rd_v, 32'h6);
      $display("test reset done");
      set_res(`SAC_RES_FULL1);
      sc_wr(6'h31);
      chk("step_angle", step_angle, 6'h39);
      set_res(`SAC_RES_QUARTER);
      step(1'b1);
      chk("step_angle", step_angle, 6'h3C);
      sc_wr(6'h3D);
      set_res(`SAC_RES_HALF_COMP);
      step(1'b1);
      chk("step_angle", step_angle, 6'h00);
      set_res(`SAC_RES_SIXTEENTH);
      step(1'b0);
      chk("step_angle", step_angle, 6'h3F);
      $display("test corners done");
      for (int i = 0; i < 42; i++) begin
         set_res(3'(i % 8));
         step(1'($urandom));
         chk_pos();
         if ($urandom % 4 == 0) begin
            sc = 6'($urandom);
            sc_wr(sc);
            chk_pos();
         end
      end
      $display("test walk done");
      wr(`SAC_OFF_CTRL, 32'h8, rsp);
      set_res(`SAC_RES_FULL1);
      repeat (3) @(posedge aclk);
      ea = 6'h00;
      chk_pos();
      wr(`SAC_OFF_CTRL, 32'hD, rsp);
      set_res(`SAC_RES_EIGHTH);
      repeat (3) @(posedge aclk);
      ea = 6'h08;
      chk_pos();
      $display("test sleep done");
      rd(`SAC_OFF_POSITION, rd_v, rsp);
      chk("position", rd_v, {26'h0, ea});
      rd(`SAC_OFF_PHASE, rd_v, rsp);
      chk("phase", rd_v, 32'h00002C2C);
      wr(8'h10, 32'h1, rsp);
      chk("bresp", {30'h0, rsp}, {30'h0, `SAC_RESP_SLVERR});
      rd(8'h14, rd_v, rsp);
      chk("rresp", {30'h0, rsp}, {30'h0, `SAC_RESP_SLVERR});
      chk("rdata", rd_v, 32'h0);
      $display("test bus done");
      stop_test();
   end
endmodule
`default_nettype wire
